/* File: src/pbm_consts.svh */
// register addresses, masks, reset values and sizes of the port configuration block
`ifndef PBM_CONSTS_SVH
`define PBM_CONSTS_SVH
`define PBM_ADDR_W          20
`define PBM_ADDR_ASEL       20'hF0017
`define PBM_ADDR_IBS0       20'hF0040
`define PBM_ADDR_IBS1       20'hF0041
`define PBM_ADDR_IBS14      20'hF004E
`define PBM_ADDR_ODS0       20'hF0050
`define PBM_ADDR_ODS1       20'hF0051
`define PBM_ADDR_ODS14      20'hF005E
`define PBM_ADDR_LATCH0     20'hFFF00
`define PBM_ADDR_LATCH1     20'hFFF01
`define PBM_ADDR_LATCH2     20'hFFF02
`define PBM_ADDR_LATCH14    20'hFFF0E
`define PBM_MASK_IBS0       8'h18
`define PBM_MASK_IBS1       8'h03
`define PBM_MASK_IBS14      8'h0C
`define PBM_MASK_ODS0       8'h1C
`define PBM_MASK_ODS1       8'h05
`define PBM_MASK_ODS14      8'h1C
`define PBM_MASK_ASEL       8'h1F
`define PBM_RST_CFG         8'h00
`define PBM_RST_ASEL        8'h10
`define PBM_RST_LATCH       8'h00
`define PBM_ASEL_ALL_DIG    5'h10
`define PBM_ASEL_MAX_SPLIT  5'h08
`define PBM_NUM_PORTS       4
`define PBM_ANALOG_PORT     2
`endif

/* File: src/pbm_pkg.sv */
// types shared by the port configuration block
package pbm_pkg;
    typedef logic [7:0] pbm_byte_t;
    typedef enum logic [3:0] {
        PBM_SEL_NONE,
        PBM_SEL_ASEL,
        PBM_SEL_IBS0,
        PBM_SEL_IBS1,
        PBM_SEL_IBS14,
        PBM_SEL_ODS0,
        PBM_SEL_ODS1,
        PBM_SEL_ODS14,
        PBM_SEL_LATCH
    } pbm_sel_e;
endpackage

/* File: src/pbm_latch_mem.sv */
// port output latches with masked write and registered read
`timescale 1ns/1ps
`include "pbm_consts.svh"
module pbm_latch_mem
    import pbm_pkg::*;
#(
    parameter int NUM = `PBM_NUM_PORTS
) (
    input  wire logic               clock_in,
    input  wire logic               rst_n_in,
    input  wire logic               wr_in,
    input  wire logic [1:0]         wr_idx_in,
    input  wire logic [7:0]         wr_mask_in,
    input  wire logic [7:0]         wr_data_in,
    input  wire logic [1:0]         rd_idx_in,
    output logic      [7:0]         rd_data_out,
    output logic      [NUM*8-1:0]   latch_out
);
    pbm_byte_t mem_q [NUM];
    pbm_byte_t rd_q;

    genvar g;
    generate
        for (g = 0; g < NUM; g++) begin : g_ent
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    mem_q[g] <= `PBM_RST_LATCH; // R18
                end else if (wr_in && wr_idx_in == 2'(g)) begin
                    mem_q[g] <= (mem_q[g] & ~wr_mask_in) | (wr_data_in & wr_mask_in); // R15 R16
                end
            end
            assign latch_out[g*8 +: 8] = mem_q[g];
        end
    endgenerate

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_q <= `PBM_RST_LATCH;
        end else begin
            rd_q <= mem_q[rd_idx_in];
        end
    end

    assign rd_data_out = rd_q;
endmodule // pbm_latch_mem

/* File: src/pbm_port_config.sv */
// port buffer mode, open-drain select, analog pin select and output latch path
// Functional notes
// (R01) input buffer select bits: reg0 bits 4,3; reg1 bits 1,0; reg14 bits 3,2
// (R02) a one selects the TTL-level input buffer, zero the normal buffer
// (R03) drive select bits: reg0 bits 4-2; reg1 bits 2,0; reg14 bits 4-2
// (R04) drive select zero gives push-pull, one gives N-channel open drain
// (R05) open drain is also usable on both simple I2C data pins
// (R06) all config registers accept 1-bit and 8-bit writes
// (R07) reset clears buffer select and drive select registers
// (R08) analog select uses bits 4-0 for port 2; bits 7-5 are zero
// (R09) reset sets analog select so all port 2 pins are digital
// (R10) code k up to 8 makes lowest k pins digital; 16 all digital
// (R11) with converter enable low, analog select ignores writes and holds reset value
// (R12) software sets converter enable before configuring analog select
// (R13) software puts conversion pins into input mode
// (R14) software never converts a pin configured as digital
// (R15) in output mode a write updates the latch and the pin drives it
// (R16) in input mode a write updates the latch but the pin stays undriven
// (R17) the latch keeps its value until the next write
// (R18) reset clears the output latches
// (R19) reading an output-mode port returns the latch, latch unchanged
// (R20) reading an input-mode port returns the pin levels, latch unchanged
// (R21) fixed-zero bits read zero and ignore writes
`timescale 1ns/1ps
`include "pbm_consts.svh"
module pbm_port_config
    import pbm_pkg::*;
(
    input  wire logic                    clock_in,
    input  wire logic                    rst_n_in,
    input  wire logic [`PBM_ADDR_W-1:0]  cpu_addr_in,
    input  wire logic                    cpu_wr_in,
    input  wire logic                    cpu_rd_in,
    input  wire logic                    cpu_bit_op_in,
    input  wire logic [2:0]              cpu_bit_sel_in,
    input  wire logic [7:0]              cpu_wdata_in,
    input  wire logic                    converter_peripheral_enable_in,
    input  wire logic [31:0]             port_input_mode_in,
    input  wire logic [31:0]             pin_level_in,
    output logic      [7:0]              cpu_rdata_out,
    output logic                         cpu_rvalid_out,
    output logic      [31:0]             pin_drive_out,
    output logic      [31:0]             pin_oe_n_out,
    output logic      [31:0]             ttl_buffer_out,
    output logic      [7:0]              analog_input_out
);
    ////////////////////////////////////////////////////////////////////////
    // decode
    pbm_sel_e   sel;
    logic [1:0] port_idx;
    logic [7:0] wmask;

    always_comb begin
        sel      = PBM_SEL_NONE;
        port_idx = 2'h0;
        case (cpu_addr_in)
            `PBM_ADDR_ASEL:    sel = PBM_SEL_ASEL;
            `PBM_ADDR_IBS0:    sel = PBM_SEL_IBS0;
            `PBM_ADDR_IBS1:    sel = PBM_SEL_IBS1;
            `PBM_ADDR_IBS14:   sel = PBM_SEL_IBS14;
            `PBM_ADDR_ODS0:    sel = PBM_SEL_ODS0;
            `PBM_ADDR_ODS1:    sel = PBM_SEL_ODS1;
            `PBM_ADDR_ODS14:   sel = PBM_SEL_ODS14;
            `PBM_ADDR_LATCH0:  sel = PBM_SEL_LATCH;
            `PBM_ADDR_LATCH1: begin
                sel      = PBM_SEL_LATCH;
                port_idx = 2'h1;
            end
            `PBM_ADDR_LATCH2: begin
                sel      = PBM_SEL_LATCH;
                port_idx = 2'h2;
            end
            `PBM_ADDR_LATCH14: begin
                sel      = PBM_SEL_LATCH;
                port_idx = 2'h3;
            end
            default:           sel = PBM_SEL_NONE;
        endcase
    end

    // single-bit operations touch one bit, byte operations all eight
    assign wmask = cpu_bit_op_in ? (8'h01 << cpu_bit_sel_in) : 8'hFF; // R06

    function automatic pbm_byte_t merge(input pbm_byte_t old, input pbm_byte_t fixed);
        merge = ((old & ~wmask) | (cpu_wdata_in & wmask)) & fixed;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    pbm_byte_t ibs0_q, ibs1_q, ibs14_q, ods0_q, ods1_q, ods14_q, asel_q;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ibs0_q  <= `PBM_RST_CFG; // R07
            ibs1_q  <= `PBM_RST_CFG;
            ibs14_q <= `PBM_RST_CFG;
        end else if (cpu_wr_in) begin
            if (sel == PBM_SEL_IBS0)  ibs0_q  <= merge(ibs0_q, `PBM_MASK_IBS0);   // R01 R21
            if (sel == PBM_SEL_IBS1)  ibs1_q  <= merge(ibs1_q, `PBM_MASK_IBS1);   // R01
            if (sel == PBM_SEL_IBS14) ibs14_q <= merge(ibs14_q, `PBM_MASK_IBS14); // R01
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ods0_q  <= `PBM_RST_CFG; // R07
            ods1_q  <= `PBM_RST_CFG;
            ods14_q <= `PBM_RST_CFG;
        end else if (cpu_wr_in) begin
            if (sel == PBM_SEL_ODS0)  ods0_q  <= merge(ods0_q, `PBM_MASK_ODS0);   // R03 R21
            if (sel == PBM_SEL_ODS1)  ods1_q  <= merge(ods1_q, `PBM_MASK_ODS1);   // R03
            if (sel == PBM_SEL_ODS14) ods14_q <= merge(ods14_q, `PBM_MASK_ODS14); // R03
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            asel_q <= `PBM_RST_ASEL; // R09
        end else if (!converter_peripheral_enable_in) begin
            asel_q <= `PBM_RST_ASEL; // R11
        end else if (cpu_wr_in && sel == PBM_SEL_ASEL) begin
            asel_q <= merge(asel_q, `PBM_MASK_ASEL); // R08 R06
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output latches
    logic [31:0] latch;
    logic [7:0]  mem_rdata;

    pbm_latch_mem #(
        .NUM (`PBM_NUM_PORTS)
    ) u_latch (
        .clock_in    (clock_in),
        .rst_n_in    (rst_n_in),
        .wr_in       (cpu_wr_in && sel == PBM_SEL_LATCH), // R15 R16 R17
        .wr_idx_in   (port_idx),
        .wr_mask_in  (wmask),
        .wr_data_in  (cpu_wdata_in),
        .rd_idx_in   (port_idx),
        .rd_data_out (mem_rdata),
        .latch_out   (latch)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    logic [31:0] pin_s1_q, pin_s2_q;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_s1_q <= 32'h0000_0000;
            pin_s2_q <= 32'h0000_0000;
        end else begin
            pin_s1_q <= pin_level_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // analog select decode and pin drive
    logic [7:0]  analog_map;
    logic [31:0] od_sel, ttl_sel, analog_all;

    // prohibited codes fall back to all-digital so no pin is lost silently
    always_comb begin
        analog_map = 8'h00;
        if (asel_q[4:0] <= `PBM_ASEL_MAX_SPLIT) begin
            analog_map = 8'hFF << asel_q[3:0]; // R10
        end
    end

    assign od_sel     = {ods14_q, 8'h00, ods1_q, ods0_q};
    assign ttl_sel    = {ibs14_q, 8'h00, ibs1_q, ibs0_q};
    assign analog_all = {8'h00, analog_map, 16'h0000};

    logic [31:0] drive_q, oe_n_q, ttl_q;
    logic [7:0]  analog_q;

    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_pin
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    drive_q[g] <= 1'b0;
                    oe_n_q[g]  <= 1'b1;
                end else begin
                    drive_q[g] <= latch[g]; // R15
                    // open drain pulls low only; a one releases the pin
                    oe_n_q[g]  <= port_input_mode_in[g] || analog_all[g] ||
                                  (od_sel[g] && latch[g]); // R04 R05 R16
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ttl_q    <= 32'h0000_0000;
            analog_q <= 8'h00;
        end else begin
            ttl_q    <= ttl_sel;    // R02
            analog_q <= analog_map; // R08
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, answer two edges after the request
    logic        rd1_q, is_port_q, rvalid_q;
    logic [7:0]  cfg_q, pin_snap_q, mode_snap_q, rdata_q;
    pbm_byte_t   cfg_val;

    always_comb begin
        case (sel)
            PBM_SEL_ASEL:  cfg_val = asel_q;
            PBM_SEL_IBS0:  cfg_val = ibs0_q;
            PBM_SEL_IBS1:  cfg_val = ibs1_q;
            PBM_SEL_IBS14: cfg_val = ibs14_q;
            PBM_SEL_ODS0:  cfg_val = ods0_q;
            PBM_SEL_ODS1:  cfg_val = ods1_q;
            PBM_SEL_ODS14: cfg_val = ods14_q;
            default:       cfg_val = 8'h00;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd1_q       <= 1'b0;
            is_port_q   <= 1'b0;
            cfg_q       <= 8'h00;
            pin_snap_q  <= 8'h00;
            mode_snap_q <= 8'h00;
        end else begin
            rd1_q       <= cpu_rd_in;
            is_port_q   <= (sel == PBM_SEL_LATCH);
            cfg_q       <= cfg_val;
            pin_snap_q  <= pin_s2_q[port_idx*8 +: 8];
            mode_snap_q <= port_input_mode_in[port_idx*8 +: 8];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 8'h00;
        end else begin
            rvalid_q <= rd1_q;
            if (rd1_q) begin
                rdata_q <= is_port_q ?
                           ((pin_snap_q & mode_snap_q) | (mem_rdata & ~mode_snap_q)) :
                           cfg_q; // R19 R20 R21
            end
        end
    end

    assign cpu_rdata_out    = rdata_q;
    assign cpu_rvalid_out   = rvalid_q;
    assign pin_drive_out    = drive_q;
    assign pin_oe_n_out     = oe_n_q;
    assign ttl_buffer_out   = ttl_q;
    assign analog_input_out = analog_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_asel_hold: // R11
    assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !converter_peripheral_enable_in |=> asel_q == `PBM_RST_ASEL)
        else $error("analog select changed while converter disabled");

    a_fixed_zero: // R21
    assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ((ibs0_q & ~`PBM_MASK_IBS0) == 8'h00) && ((ods1_q & ~`PBM_MASK_ODS1) == 8'h00)
        && (asel_q[7:5] == 3'h0))
        else $error("fixed-zero bit set");

    a_bit_write: // R06
    assert property (@(posedge clock_in) disable iff (!rst_n_in)
        cpu_wr_in && cpu_bit_op_in && sel == PBM_SEL_ODS0 && cpu_bit_sel_in == 3'h2
        |=> ods0_q[2] == $past(cpu_wdata_in[2]) && ods0_q[4:3] == $past(ods0_q[4:3]))
        else $error("single-bit write wrong");

    a_analog_map: // R10
    assert property (@(posedge clock_in) disable iff (!rst_n_in)
        asel_q[4:0] == 5'h03 |=> analog_input_out == 8'hF8)
        else $error("analog map wrong for code 3");

    a_od_release: // R04
    assert property (@(posedge clock_in) disable iff (!rst_n_in)
        od_sel[2] && latch[2] |=> pin_oe_n_out[2])
        else $error("open drain drove a high");

    a_pp_drive: // R15
    assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !port_input_mode_in[8] && !od_sel[8]
        |=> !pin_oe_n_out[8] && pin_drive_out[8] == $past(latch[8]))
        else $error("push-pull pin not driving latch");

    a_input_off: // R16
    assert property (@(posedge clock_in) disable iff (!rst_n_in)
        1'b1 |=> (pin_oe_n_out & $past(port_input_mode_in)) == $past(port_input_mode_in))
        else $error("input-mode pin driven");

    a_latch_keep: // R17
    assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !(cpu_wr_in && sel == PBM_SEL_LATCH) |=> $stable(latch))
        else $error("latch changed without write");

    a_read_time: // R19
    assert property (@(posedge clock_in) disable iff (!rst_n_in)
        cpu_rd_in |-> ##2 cpu_rvalid_out)
        else $error("read answer late");

    a_ttl_follow: // R02
    assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ##1 ttl_buffer_out == $past(ttl_sel))
        else $error("buffer select not following register");

    c_od_write: cover property (@(posedge clock_in) disable iff (!rst_n_in)
        cpu_wr_in && sel == PBM_SEL_ODS14);
    c_asel_split: cover property (@(posedge clock_in) disable iff (!rst_n_in)
        asel_q[4:0] == 5'h04);
    c_port_read: cover property (@(posedge clock_in) disable iff (!rst_n_in)
        cpu_rd_in && sel == PBM_SEL_LATCH ##2 cpu_rvalid_out);
endmodule // pbm_port_config

/* File: tb/pbm_pin_partner.sv */
// pin-side model: external pull-ups on every pin plus an optional external driver
`timescale 1ns/1ps
module pbm_pin_partner (
    input  wire logic [31:0] pin_drive_in,
    input  wire logic [31:0] pin_oe_n_in,
    input  wire logic [31:0] ext_en_in,
    input  wire logic [31:0] ext_val_in,
    output logic      [31:0] pin_level_out
);
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (!pin_oe_n_in[i]) begin
                pin_level_out[i] = pin_drive_in[i];
            end else if (ext_en_in[i]) begin
                pin_level_out[i] = ext_val_in[i];
            end else begin
                // released or open-drain high pins float up to the pull-up
                pin_level_out[i] = 1'b1;
            end
        end
    end
endmodule // pbm_pin_partner

/* File: tb/pbm_port_config_tb.sv */
// self-checking bench for the port configuration block
`timescale 1ns/1ps
`include "pbm_consts.svh"
module pbm_port_config_tb;
    import pbm_pkg::*;
    logic                   clock_in = 1'b0;
    logic                   rst_n_in = 1'b0;
    logic [`PBM_ADDR_W-1:0] cpu_addr = '0;
    logic                   cpu_wr = 1'b0;
    logic                   cpu_rd = 1'b0;
    logic                   cpu_bit_op = 1'b0;
    logic [2:0]             cpu_bit_sel = '0;
    logic [7:0]             cpu_wdata = '0;
    logic                   adc_en = 1'b0;
    logic [31:0]            in_mode = '0;
    logic [31:0]            ext_en = '0;
    logic [31:0]            ext_val = '0;
    logic [31:0]            pin_level;
    logic [7:0]             rdata;
    logic                   rvalid;
    logic [31:0]            drive;
    logic [31:0]            oe_n;
    logic [31:0]            ttl;
    logic [7:0]             analog;
    int                     n_mismatch = 0;
    int                     checks_done = 0;
    localparam logic [19:0] CFG_A [7] = '{`PBM_ADDR_ASEL, `PBM_ADDR_IBS0, `PBM_ADDR_IBS1,
        `PBM_ADDR_IBS14, `PBM_ADDR_ODS0, `PBM_ADDR_ODS1, `PBM_ADDR_ODS14};
    localparam logic [7:0]  CFG_M [7] = '{`PBM_MASK_ASEL, `PBM_MASK_IBS0, `PBM_MASK_IBS1,
        `PBM_MASK_IBS14, `PBM_MASK_ODS0, `PBM_MASK_ODS1, `PBM_MASK_ODS14};

    always #25 clock_in = ~clock_in;

    pbm_port_config dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .cpu_addr_in(cpu_addr),
        .cpu_wr_in(cpu_wr), .cpu_rd_in(cpu_rd), .cpu_bit_op_in(cpu_bit_op),
        .cpu_bit_sel_in(cpu_bit_sel), .cpu_wdata_in(cpu_wdata),
        .converter_peripheral_enable_in(adc_en), .port_input_mode_in(in_mode),
        .pin_level_in(pin_level), .cpu_rdata_out(rdata), .cpu_rvalid_out(rvalid),
        .pin_drive_out(drive), .pin_oe_n_out(oe_n), .ttl_buffer_out(ttl),
        .analog_input_out(analog));

    pbm_pin_partner partner (.pin_drive_in(drive), .pin_oe_n_in(oe_n), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .pin_level_out(pin_level));

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // entered at a falling edge; the extra edge keeps back-to-back strobes apart
    task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic bop = 1'b0,
                      input logic [2:0] bs = 3'h0);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_bit_op = bop;
        cpu_bit_sel = bs;
        cpu_wr = 1'b1;
        @(negedge clock_in);
        cpu_wr = 1'b0;
        @(negedge clock_in);
    endtask

    task automatic rchk(input string what, input logic [19:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clock_in);
        cpu_rd = 1'b0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(negedge clock_in);
            n++;
        end
        check({what, " rvalid"}, {31'h0, rvalid}, 32'h1);
        check(what, {24'h0, rdata}, {24'h0, exp});
        @(negedge clock_in);
    endtask

    task automatic settle();
        repeat (4) @(negedge clock_in);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 7; i++) begin
            rchk("cfg reset", CFG_A[i], (i == 0) ? `PBM_RST_ASEL : `PBM_RST_CFG);
        end
        rchk("latch0 reset", `PBM_ADDR_LATCH0, `PBM_RST_LATCH);
        rchk("latch14 reset", `PBM_ADDR_LATCH14, `PBM_RST_LATCH);
        $display("test reset done");
    endtask

    task automatic t_cfg();
        for (int i = 1; i < 7; i++) begin
            wr(CFG_A[i], 8'hFF);
            rchk("cfg byte", CFG_A[i], CFG_M[i]);
        end
        check("ttl", ttl, {`PBM_MASK_IBS14, 8'h00, `PBM_MASK_IBS1, `PBM_MASK_IBS0});
        wr(`PBM_ADDR_IBS0, 8'h00, 1'b1, 3'h3);
        rchk("ibs0 bit clear", `PBM_ADDR_IBS0, 8'h10);
        // data bit 1 is zero, the other data bits must not leak in
        wr(`PBM_ADDR_IBS1, 8'hFD, 1'b1, 3'h1);
        rchk("ibs1 bit clear", `PBM_ADDR_IBS1, 8'h01);
        wr(20'hF0042, 8'hFF);
        rchk("unmapped", 20'hF0042, 8'h00);
        for (int i = 1; i < 7; i++) begin
            wr(CFG_A[i], 8'h00);
        end
        wr(`PBM_ADDR_ODS0, 8'h04, 1'b1, 3'h2);
        rchk("ods0 bit set", `PBM_ADDR_ODS0, 8'h04);
        wr(`PBM_ADDR_ODS0, 8'h00);
        $display("test config done");
    endtask

    task automatic t_analog_digital_pin_select();
        logic [7:0] code;
        logic [7:0] exp;
        in_mode[23:16] = 8'hFF;
        wr(`PBM_ADDR_ASEL, 8'h05);
        rchk("asel disabled", `PBM_ADDR_ASEL, `PBM_RST_ASEL);
        adc_en = 1'b1;
        for (int k = 0; k < 10; k++) begin
            code = (k == 9) ? 8'h10 : 8'(k);
            exp = 8'hFF << code;
            wr(`PBM_ADDR_ASEL, code);
            rchk("asel code", `PBM_ADDR_ASEL, code);
            check("analog", {24'h0, analog}, {24'h0, exp});
        end
        wr(`PBM_ADDR_ASEL, 8'hE3);
        rchk("asel high bits", `PBM_ADDR_ASEL, 8'h03);
        adc_en = 1'b0;
        settle();
        rchk("asel forced", `PBM_ADDR_ASEL, `PBM_RST_ASEL);
        check("analog forced", {24'h0, analog}, 32'h0);
        in_mode[23:16] = 8'h00;
        $display("test analog select done");
    endtask

    task automatic t_pins();
        wr(`PBM_ADDR_LATCH0, 8'h1C);
        settle();
        check("push-pull oe_n", {29'h0, oe_n[4:2]}, 32'h0);
        check("push-pull drive", {29'h0, drive[4:2]}, 32'h7);
        wr(`PBM_ADDR_ODS0, 8'h1C);
        wr(`PBM_ADDR_LATCH0, 8'h14);
        settle();
        check("open-drain oe_n", {29'h0, oe_n[4:2]}, 32'h5);
        check("open-drain pin", {29'h0, pin_level[4:2]}, 32'h5);
        rchk("latch0 out", `PBM_ADDR_LATCH0, 8'h14);
        wr(`PBM_ADDR_ODS14, 8'h08);
        wr(`PBM_ADDR_LATCH14, 8'h08);
        settle();
        check("sda b released", {31'h0, oe_n[27]}, 32'h1);
        wr(`PBM_ADDR_LATCH14, 8'h00);
        settle();
        check("sda b low", {31'h0, oe_n[27]}, 32'h0);
        in_mode[15:8] = 8'hFF;
        ext_en[15:8] = 8'hFF;
        ext_val[15:8] = 8'hA5;
        wr(`PBM_ADDR_LATCH1, 8'h5A);
        settle();
        check("input oe_n", {24'h0, oe_n[15:8]}, 32'hFF);
        check("input pin", {24'h0, pin_level[15:8]}, 32'hA5);
        rchk("latch1 in", `PBM_ADDR_LATCH1, 8'hA5);
        in_mode[15:8] = 8'h00;
        ext_en[15:8] = 8'h00;
        settle();
        rchk("latch1 out", `PBM_ADDR_LATCH1, 8'h5A);
        check("output drive", {24'h0, drive[15:8]}, 32'h5A);
        $display("test pins done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #(50 * 5000);
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (16) @(negedge clock_in);
        rst_n_in = 1'b1;
        @(negedge clock_in);
        t_reset();
        t_cfg();
        t_analog_digital_pin_select();
        t_pins();
        final_report();
    end
endmodule // pbm_port_config_tb
